// ---- core/sdwb_core.sv ----
// device side of write bursts and read auto precharge
`timescale 1ns/100ps
module sdwb_core import sdwb_pkg::*; #(
   parameter int DQ_W  = 8,
   parameter int COL_W = 10,
   parameter int ROW_W = 14
)(
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // memory link command pins
   input  wire logic              ck,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [ROW_W-1:0]  addr,
   input  wire logic [1:0]        bank_select,
   // memory link data pins
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic      [DQ_W-1:0]   dq_out,
   output logic                   dq_oe,
   input  wire logic              dqs_in,
   output logic                   dqs_out,
   output logic                   dqs_oe,
   input  wire logic              write_byte_mask
);
   localparam int SW = 2 + 4 + ROW_W + 2 + DQ_W + 1;
   localparam int EW = 2 + COL_W + DQ_W;
   localparam int IW = 2 + COL_W;

   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      return (v == 8'hff) ? v : v + 8'h01;
   endfunction

   function automatic logic [COL_W-1:0] elem_col(input logic [COL_W-1:0] s,
                                                 input logic [2:0] b, input logic b8);
      logic [COL_W-1:0] c;
      c = s;
      if (b8) begin
         c[2:0] = s[2:0] + b;
      end else begin
         c[1:0] = s[1:0] + b[1:0];
      end
      return c;
   endfunction

   // synchronised pins
   logic [SW-1:0]    pins_s;
   logic             ck_s, dqs_s, mask_s;
   logic [3:0]       cmd_s;
   logic [ROW_W-1:0] addr_s;
   logic [1:0]       bank_s;
   logic [DQ_W-1:0]  dq_s;
   logic             ck_d_reg, dqs_d_reg;
   logic             ck_rise, dqs_rise, dqs_fall;

   sdwb_sync #(.W(SW)) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({ck, dqs_in, cs_n, ras_n, cas_n, we_n, addr, bank_select, dq_in,
                  write_byte_mask}),
      .sync_out (pins_s)
   );
   assign {ck_s, dqs_s, cmd_s, addr_s, bank_s, dq_s, mask_s} = pins_s;
   assign ck_rise  = ck_s && !ck_d_reg;
   assign dqs_rise = dqs_s && !dqs_d_reg;
   assign dqs_fall = !dqs_s && dqs_d_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_d_reg  <= 1'b0;
         dqs_d_reg <= 1'b0;
      end else begin
         ck_d_reg  <= ck_s;
         dqs_d_reg <= dqs_s;
      end
   end

   // configuration values
   logic [31:0] cfg_reg, cfg_next;
   logic [31:0] tim_reg, tim_next;
   logic [2:0]  al, cl;
   logic        bl8;
   logic [3:0]  read_latency, write_latency, half_burst;
   logic [2:0]  last_beat;

   assign al            = cfg_reg[CFG_AL_LSB +: 3];
   assign cl            = cfg_reg[CFG_CL_LSB +: 3];
   assign bl8           = cfg_reg[CFG_BL8_BIT];
   assign read_latency  = {1'b0, al} + {1'b0, cl};
   assign write_latency = read_latency - WRITE_LAT_OFFSET;
   assign half_burst    = bl8 ? HALF_BURST_8 : HALF_BURST_4;
   assign last_beat     = bl8 ? LAST_BEAT_8 : LAST_BEAT_4;

   // data pins are never driven by this block
   assign dq_out  = '0;
   assign dq_oe   = 1'b0;
   assign dqs_out = 1'b0;
   assign dqs_oe  = 1'b0;

   // write scheduling: two waiting commands and one live burst
   logic [1:0]       sv_reg, sv_next;
   logic [3:0]       sc_reg [2], sc_next [2];
   logic [1:0]       sb_reg [2], sb_next [2];
   logic [COL_W-1:0] scol_reg [2], scol_next [2];
   logic             sap_reg [2], sap_next [2];
   logic             bact_reg, bact_next, bfirst_reg, bfirst_next, bap_reg, bap_next;
   logic [1:0]       bbank_reg, bbank_next;
   logic [COL_W-1:0] bcol_reg, bcol_next;
   logic [2:0]       bbeat_reg, bbeat_next;
   logic [7:0]       drop_reg, drop_next;
   logic             wr_close, fin_valid, fin_ready;
   logic [EW-1:0]    fin_data;

   always_comb begin
      sv_next     = sv_reg;
      sc_next     = sc_reg;
      sb_next     = sb_reg;
      scol_next   = scol_reg;
      sap_next    = sap_reg;
      bact_next   = bact_reg;
      bfirst_next = bfirst_reg;
      bap_next    = bap_reg;
      bbank_next  = bbank_reg;
      bcol_next   = bcol_reg;
      bbeat_next  = bbeat_reg;
      drop_next   = drop_reg;
      wr_close    = 1'b0;
      fin_valid   = 1'b0;
      fin_data    = {bbank_reg, elem_col(bcol_reg, bbeat_reg, bl8), dq_s};
      for (int i = 0; i < 2; i++) begin
         if (ck_rise && sv_reg[i] && sc_reg[i] != 4'h0) begin
            sc_next[i] = sc_reg[i] - 4'h1;
         end
      end
      // strobes outside a burst are ignored
      if (bact_reg && (dqs_rise || (bfirst_reg && dqs_fall))) begin
         bfirst_next = 1'b1;
         fin_valid   = !mask_s;
         if (!mask_s && !fin_ready) begin
            drop_next = sat_inc(drop_reg);
         end
         bbeat_next = bbeat_reg + 3'h1;
         if (bbeat_reg == last_beat) begin
            bact_next = 1'b0;
            wr_close  = bap_reg;
         end else if (bbeat_reg == LAST_BEAT_4 && bl8 && !bap_reg && sv_reg[0]
                      && sc_next[0] == 4'h0) begin
            bact_next = 1'b0;
         end
      end
      if (!bact_next && sv_next[0] && sc_next[0] == 4'h0) begin
         bact_next    = 1'b1;
         bfirst_next  = 1'b0;
         bbeat_next   = 3'h0;
         bbank_next   = sb_next[0];
         bcol_next    = scol_next[0];
         bap_next     = sap_next[0];
         sv_next      = {1'b0, sv_next[1]};
         sc_next[0]   = sc_next[1];
         sb_next[0]   = sb_next[1];
         scol_next[0] = scol_next[1];
         sap_next[0]  = sap_next[1];
      end
      if (ck_rise && cmd_s == CMD_WRITE) begin
         for (int i = 1; i >= 0; i--) begin
            if (!sv_next[i] && (i == 0 || sv_next[0])) begin
               sv_next[i]   = 1'b1;
               sc_next[i]   = (write_latency == 4'h0) ? 4'h0 : write_latency - 4'h1;
               sb_next[i]   = bank_s;
               scol_next[i] = addr_s[COL_W-1:0];
               sap_next[i]  = addr_s[AUTO_PRE_BIT];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sv_reg     <= 2'h0;
         sc_reg     <= '{default: 4'h0};
         sb_reg     <= '{default: 2'h0};
         scol_reg   <= '{default: '0};
         sap_reg    <= '{default: 1'b0};
         bact_reg   <= 1'b0;
         bfirst_reg <= 1'b0;
         bap_reg    <= 1'b0;
         bbank_reg  <= 2'h0;
         bcol_reg   <= '0;
         bbeat_reg  <= 3'h0;
         drop_reg   <= 8'h00;
      end else begin
         sv_reg     <= sv_next;
         sc_reg     <= sc_next;
         sb_reg     <= sb_next;
         scol_reg   <= scol_next;
         sap_reg    <= sap_next;
         bact_reg   <= bact_next;
         bfirst_reg <= bfirst_next;
         bap_reg    <= bap_next;
         bbank_reg  <= bbank_next;
         bcol_reg   <= bcol_next;
         bbeat_reg  <= bbeat_next;
         drop_reg   <= drop_next;
      end
   end

   // bank rows and auto precharge
   logic [NUM_BANKS-1:0] open_reg, open_next, app_reg, app_next;
   logic [7:0]           ras_reg [NUM_BANKS], ras_next [NUM_BANKS];
   logic [7:0]           rtp_reg [NUM_BANKS], rtp_next [NUM_BANKS];
   logic [3:0]           rdw_reg [NUM_BANKS], rdw_next [NUM_BANKS];
   logic [7:0]           pre_reg, pre_next;

   always_comb begin
      open_next = open_reg;
      app_next  = app_reg;
      ras_next  = ras_reg;
      rtp_next  = rtp_reg;
      rdw_next  = rdw_reg;
      pre_next  = pre_reg;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (ck_rise) begin
            ras_next[i] = sat_inc(ras_reg[i]);
            rtp_next[i] = sat_inc(rtp_reg[i]);
            if (rdw_reg[i] != 4'h0) begin
               rdw_next[i] = rdw_reg[i] - 4'h1;
            end
         end
         if (app_reg[i] && rdw_reg[i] == 4'h0 && ras_reg[i] >= tim_reg[TIM_RAS_LSB +: 8]
             && rtp_reg[i] >= tim_reg[TIM_RTP_LSB +: 8]) begin
            open_next[i] = 1'b0;
            app_next[i]  = 1'b0;
            pre_next     = sat_inc(pre_next);
         end
         if (wr_close && bbank_reg == 2'(i)) begin
            open_next[i] = 1'b0;
            pre_next     = sat_inc(pre_next);
         end
         if (ck_rise && bank_s == 2'(i) && cmd_s == CMD_ACTIVE) begin
            open_next[i] = 1'b1;
            ras_next[i]  = 8'h00;
         end
         if (ck_rise && bank_s == 2'(i) && cmd_s == CMD_READ) begin
            rtp_next[i] = 8'h00;
            if (addr_s[AUTO_PRE_BIT]) begin
               app_next[i] = 1'b1;
               rdw_next[i] = {1'b0, al} + half_burst;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         open_reg <= '0;
         app_reg  <= '0;
         ras_reg  <= '{default: 8'h00};
         rtp_reg  <= '{default: 8'h00};
         rdw_reg  <= '{default: 4'h0};
         pre_reg  <= 8'h00;
      end else begin
         open_reg <= open_next;
         app_reg  <= app_next;
         ras_reg  <= ras_next;
         rtp_reg  <= rtp_next;
         rdw_reg  <= rdw_next;
         pre_reg  <= pre_next;
      end
   end

   // captured elements into the array
   logic [DQ_W-1:0] mem [2**IW];
   logic            fout_valid, fout_ready;
   logic [EW-1:0]   fout_data;

   sdwb_fifo2 #(.W(EW)) u_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (fin_valid),
      .in_ready  (fin_ready),
      .in_data   (fin_data),
      .out_valid (fout_valid),
      .out_ready (fout_ready),
      .out_data  (fout_data)
   );

   always_ff @(posedge hclk) begin
      if (fout_valid && fout_ready) begin
         mem[fout_data[EW-1:DQ_W]] <= fout_data[DQ_W-1:0];
      end
   end

   // ahb-lite registers
   sdwb_phase_type st_reg, st_next;
   logic [7:0]     dpa_reg, dpa_next;
   logic [IW-1:0]  widx_reg, widx_next;
   logic [31:0]    hrdata_reg, hrdata_next, rd_word;

   assign hreadyout  = (st_reg != AHB_READ_WAIT);
   assign hresp      = 1'b0;
   assign hrdata     = hrdata_reg;
   assign fout_ready = !(st_reg == AHB_READ_WAIT && dpa_reg == WORD_DATA_OFFSET);

   always_comb begin
      case (dpa_reg)
         CONFIG_OFFSET:    rd_word = cfg_reg;
         TIMING_OFFSET:    rd_word = tim_reg;
         STATUS_OFFSET:    rd_word = {drop_reg, pre_reg, write_latency, read_latency,
                                      2'h0, sv_reg != 2'h0, bact_reg, open_reg};
         WORD_ADDR_OFFSET: rd_word = 32'(widx_reg);
         WORD_DATA_OFFSET: rd_word = 32'(mem[widx_reg]);
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_next     = st_reg;
      dpa_next    = dpa_reg;
      cfg_next    = cfg_reg;
      tim_next    = tim_reg;
      widx_next   = widx_reg;
      hrdata_next = hrdata_reg;
      case (st_reg)
         AHB_IDLE: begin
         end
         AHB_WRITE: begin
            case (dpa_reg)
               CONFIG_OFFSET:    cfg_next  = {25'h0, hwdata[6:0]};
               TIMING_OFFSET:    tim_next  = {16'h0, hwdata[15:0]};
               WORD_ADDR_OFFSET: widx_next = hwdata[IW-1:0];
               default:          cfg_next  = cfg_reg;
            endcase
         end
         AHB_READ_WAIT: begin
            hrdata_next = rd_word;
            st_next     = AHB_READ_DONE;
         end
         AHB_READ_DONE: begin
         end
         default: st_next = AHB_IDLE;
      endcase
      if (hready && st_reg != AHB_READ_WAIT) begin
         if (hsel && htrans[1]) begin
            st_next  = hwrite ? AHB_WRITE : AHB_READ_WAIT;
            dpa_next = haddr[7:0];
         end else begin
            st_next = AHB_IDLE;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg     <= AHB_IDLE;
         dpa_reg    <= 8'h00;
         cfg_reg    <= CONFIG_RESET;
         tim_reg    <= TIMING_RESET;
         widx_reg   <= '0;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         st_reg     <= st_next;
         dpa_reg    <= dpa_next;
         cfg_reg    <= cfg_next;
         tim_reg    <= tim_next;
         widx_reg   <= widx_next;
         hrdata_reg <= hrdata_next;
      end
   end
endmodule // sdwb_core

// ---- core/sdwb_pkg.sv ----
// constants of the sdram write burst and read precharge block
package sdwb_pkg;
   // register offsets
   localparam logic [7:0]  CONFIG_OFFSET    = 8'h00;
   localparam logic [7:0]  TIMING_OFFSET    = 8'h04;
   localparam logic [7:0]  STATUS_OFFSET    = 8'h08;
   localparam logic [7:0]  WORD_ADDR_OFFSET = 8'h0c;
   localparam logic [7:0]  WORD_DATA_OFFSET = 8'h10;
   // field positions
   localparam int          CFG_AL_LSB       = 0;
   localparam int          CFG_CL_LSB       = 3;
   localparam int          CFG_BL8_BIT      = 6;
   localparam int          TIM_RAS_LSB      = 0;
   localparam int          TIM_RTP_LSB      = 8;
   // reset values
   localparam logic [31:0] CONFIG_RESET     = 32'h0000_0018;
   localparam logic [31:0] TIMING_RESET     = 32'h0000_0206;
   // timing counts in link clocks, last beat numbers in strobe beats
   localparam logic [3:0]  WRITE_LAT_OFFSET = 4'h1;
   localparam logic [3:0]  HALF_BURST_4     = 4'h2;
   localparam logic [3:0]  HALF_BURST_8     = 4'h4;
   localparam logic [2:0]  LAST_BEAT_4      = 3'h3;
   localparam logic [2:0]  LAST_BEAT_8      = 3'h7;
   // command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0]  CMD_ACTIVE       = 4'h3;
   localparam logic [3:0]  CMD_READ         = 4'h5;
   localparam logic [3:0]  CMD_WRITE        = 4'h4;
   localparam int          AUTO_PRE_BIT     = 10;
   localparam int          NUM_BANKS        = 4;
   // bus phases
   typedef enum logic [1:0] {
      AHB_IDLE,
      AHB_WRITE,
      AHB_READ_WAIT,
      AHB_READ_DONE
   } sdwb_phase_type;
endpackage

// ---- core/sdwb_sync.sv ----
// two flip-flop synchroniser for link pins
`timescale 1ns/100ps
module sdwb_sync #(
   parameter int W = 1
)(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // pins
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // sdwb_sync

// ---- core/sdwb_fifo2.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module sdwb_fifo2 #(
   parameter int W = 8
)(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   logic [W-1:0] e0_reg, e0_next;
   logic [W-1:0] e1_reg, e1_next;
   logic [1:0]   cnt_reg, cnt_next;
   logic         push, pop;

   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = e0_reg;

   always_comb begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      e0_next = e0_reg;
      e1_next = e1_reg;
      cnt_next = cnt_reg;
      if (pop) begin
         e0_next = e1_reg;
      end
      if (push) begin
         if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
            e0_next = in_data;
         end else begin
            e1_next = in_data;
         end
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         e0_reg  <= '0;
         e1_reg  <= '0;
         cnt_reg <= 2'h0;
      end else begin
         e0_reg  <= e0_next;
         e1_reg  <= e1_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule // sdwb_fifo2

// ---- verification/sdwb_chk.sv ----
// checker of the bus and link outputs
`timescale 1ns/100ps
module sdwb_chk #(
   parameter int DQ_W = 8
)(
   // clock and reset
   input wire logic            hclk,
   input wire logic            hresetn,
   // bus
   input wire logic            hsel,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic            hready,
   input wire logic [31:0]     hrdata,
   input wire logic            hreadyout,
   input wire logic            hresp,
   // link outputs
   input wire logic [DQ_W-1:0] dq_out,
   input wire logic            dq_oe,
   input wire logic            dqs_out,
   input wire logic            dqs_oe
);
   logic rd_take;
   logic wr_take;
   logic rd_wait_reg;
   logic rd_wait_next;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign wr_take = hsel && htrans[1] && hready && hwrite;
   // read data phase tracker
   always_comb begin
      rd_wait_next = rd_wait_reg;
      if (rd_take) begin
         rd_wait_next = 1'b1;
      end else if (hreadyout) begin
         rd_wait_next = 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_wait_reg <= 1'b0;
      else rd_wait_reg <= rd_wait_next;
   end
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   AST_READ_WAIT: assert property (rd_take |=> s_one_wait)
      else $error("read wait not one cycle");
   AST_WRITE_NO_WAIT: assert property (wr_take |=> hreadyout)
      else $error("write wait inserted");
   AST_IDLE_READY: assert property (!rd_take && !rd_wait_reg |=> hreadyout)
      else $error("wait without read");
   AST_WAIT_SHORT: assert property ($fell(hreadyout) |=> $rose(hreadyout))
      else $error("wait too long");
   AST_HRDATA_HOLD: assert property (!rd_take && !rd_wait_reg |=> $stable(hrdata))
      else $error("read data moved");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");
   AST_DQ_QUIET: assert property (!dq_oe && dq_out == '0)
      else $error("data pins driven");
   AST_DQS_QUIET: assert property (!dqs_oe && !dqs_out)
      else $error("strobe driven");
endmodule // sdwb_chk

bind sdwb_core sdwb_chk #(.DQ_W(DQ_W)) u_sdwb_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe)
);

// ---- verification/sdwb_ctl_model.sv ----
// memory controller model for command and write data pins
`timescale 1ns/100ps
module sdwb_ctl_model import sdwb_pkg::*; #(
   parameter int DQ_W  = 8,
   parameter int ROW_W = 14
)(
   // command pins
   output logic             ck,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [ROW_W-1:0] addr,
   output logic [1:0]       bank_select,
   // data pins
   output logic [DQ_W-1:0]  dq_in,
   output logic             dqs_in,
   output logic             write_byte_mask
);
   // write latency in ck clocks, set by the bench
   int wl_clk = 2;
   // free running link clock, phase unrelated to hclk
   initial begin
      ck = 1'b0;
      #3;
      forever #80 ck = ~ck;
   end
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      addr = '0;
      bank_select = 2'h0;
      dq_in = '0;
      dqs_in = 1'b0;
      write_byte_mask = 1'b0;
   end
   // one command held across one rising ck edge, never a precharge
   task automatic issue(input logic [3:0] code, input logic [1:0] ba,
                        input logic [9:0] col, input logic ap);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = code;
      bank_select = ba;
      addr = ROW_W'(col);
      addr[AUTO_PRE_BIT] = ap;
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      addr = ~addr;
      bank_select = ~ba;
   endtask
   // write burst, second write two clocks later when nb exceeds bl
   task automatic burst(input logic [1:0] ba, input logic [9:0] c0, input logic [9:0] c1,
                        input logic ap, input int bl, input int nb,
                        input logic [7:0] base, input logic [15:0] msk);
      fork
         begin
            issue(CMD_WRITE, ba, c0, ap);
            if (nb > bl) issue(CMD_WRITE, ba, c1, 1'b0);
         end
         begin
            @(negedge ck);
            repeat (wl_clk) @(posedge ck);
            #120;
            for (int k = 0; k < nb; k++) begin
               dq_in = DQ_W'(base + 8'(k));
               write_byte_mask = msk[k];
               #40 dqs_in = ~dqs_in;
               #40;
            end
            dq_in = ~dq_in;
            write_byte_mask = ~write_byte_mask;
         end
      join
   endtask
   // strobe pulse with no burst armed
   task automatic stray();
      @(negedge ck);
      dq_in = '1;
      write_byte_mask = 1'b0;
      #40 dqs_in = 1'b1;
      #80 dqs_in = 1'b0;
      #40 dq_in = '0;
   endtask
endmodule // sdwb_ctl_model

// ---- verification/test_sdram_write_burst_and_read_precharge.sv ----
// self-checking testbench of the write burst block
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %h want %h", $time, (g), (e)); end end
module test_sdram_write_burst_and_read_precharge import sdwb_pkg::*; ;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        ck;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [13:0] addr;
   logic [1:0]  bank_select;
   logic [7:0]  dq_in;
   logic [7:0]  dq_out;
   logic        dq_oe;
   logic        dqs_in;
   logic        dqs_out;
   logic        dqs_oe;
   logic        write_byte_mask;
   logic [31:0] rdat;
   logic [7:0]  byte_q;
   int          miscompares = 0;
   int          checks_done = 0;
   sdwb_core dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ck(ck), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select(bank_select),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in),
      .dqs_out(dqs_out), .dqs_oe(dqs_oe), .write_byte_mask(write_byte_mask)
   );
   sdwb_ctl_model #(.DQ_W(8), .ROW_W(14)) ctl (
      .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
      .bank_select(bank_select), .dq_in(dq_in), .dqs_in(dqs_in),
      .write_byte_mask(write_byte_mask)
   );
   always #5 hclk = ~hclk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_ready();
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rdat = hrdata;
      @(posedge hclk);
   endtask
   task automatic peek(input logic [1:0] ba, input logic [9:0] col);
      ahb(1'b1, WORD_ADDR_OFFSET, {20'h0, ba, col});
      ahb(1'b0, WORD_DATA_OFFSET, 32'h0);
      byte_q = rdat[7:0];
   endtask
   task automatic test_regs();
      ahb(1'b0, CONFIG_OFFSET, 32'h0);
      `CHK(rdat, CONFIG_RESET)
      ahb(1'b0, TIMING_OFFSET, 32'h0);
      `CHK(rdat, TIMING_RESET)
      for (int al = 0; al < 2; al++) begin
         ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET + 32'(al));
         ahb(1'b0, STATUS_OFFSET, 32'h0);
         `CHK(rdat[11:8], 4'(3 + al))
         `CHK(rdat[15:12], 4'(3 + al - 1))
      end
      ahb(1'b1, 8'h40, 32'hffff_ffff);
      ahb(1'b0, 8'h40, 32'h0);
      `CHK(rdat, 32'h0)
      ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET);
      $display("test regs done");
   endtask
   task automatic test_mask();
      ctl.burst(2'h1, 10'h00a, 10'h000, 1'b0, 4, 4, 8'h10, 16'h0000);
      ctl.burst(2'h1, 10'h00a, 10'h000, 1'b0, 4, 4, 8'h20, 16'h0002);
      ctl.stray();
      repeat (20) @(posedge hclk);
      for (int k = 0; k < 4; k++) begin
         peek(2'h1, {8'h02, 2'(2 + k)});
         `CHK(byte_q, (k == 1) ? 8'h11 : 8'(8'h20 + k))
      end
      $display("test mask done");
   endtask
   task automatic test_concat();
      ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET + 32'h1);
      ctl.wl_clk = 3;
      ctl.burst(2'h2, 10'h004, 10'h008, 1'b0, 4, 8, 8'h40, 16'h0000);
      ctl.wl_clk = 2;
      ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET);
      repeat (20) @(posedge hclk);
      for (int k = 0; k < 8; k++) begin
         peek(2'h2, 10'(10'h004 + k));
         `CHK(byte_q, 8'(8'h40 + k))
      end
      $display("test concat done");
   endtask
   task automatic test_trunc();
      ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET | (32'h1 << CFG_BL8_BIT));
      ctl.burst(2'h3, 10'h010, 10'h030, 1'b0, 8, 12, 8'h60, 16'h0000);
      repeat (20) @(posedge hclk);
      for (int k = 0; k < 12; k++) begin
         peek(2'h3, (k < 4) ? 10'(10'h010 + k) : 10'(10'h02c + k));
         `CHK(byte_q, 8'(8'h60 + k))
      end
      ahb(1'b1, CONFIG_OFFSET, CONFIG_RESET);
      $display("test trunc done");
   endtask
   task automatic test_precharge();
      ctl.burst(2'h0, 10'h020, 10'h000, 1'b1, 4, 4, 8'h70, 16'h0000);
      repeat (20) @(posedge hclk);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK(rdat[1:0], 2'b10)
      `CHK(rdat[23:16], 8'h01)
      `CHK(rdat[5:4], 2'b00)
      ctl.issue(CMD_ACTIVE, 2'h0, 10'h000, 1'b0);
      ctl.issue(CMD_READ, 2'h0, 10'h000, 1'b1);
      repeat (3) @(posedge ck);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK(rdat[0], 1'b1)
      repeat (3) @(posedge ck);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK(rdat[0], 1'b0)
      `CHK(rdat[23:16], 8'h02)
      `CHK(rdat[31:24], 8'h00)
      $display("test precharge done");
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      for (int b = 0; b < NUM_BANKS; b++) ctl.issue(CMD_ACTIVE, 2'(b), 10'h000, 1'b0);
      test_regs();
      test_mask();
      test_concat();
      test_trunc();
      test_precharge();
      give_verdict();
   end
endmodule // test_sdram_write_burst_and_read_precharge
